// ### pdl_host.sv
`timescale 1ns/100ps
module pdl_host (
    input  wire logic        mclk,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_rvalid,
    output logic             cfg_rd = 1'b0,
    output logic             cfg_wr = 1'b0,
    output logic [7:0]       cfg_addr = 8'h00,
    output logic [31:0]      cfg_wdata = 32'h0,
    output logic [3:0]       cfg_be = 4'h0,
    output logic             common_refclk_sel = 1'b0
);
    // link control bit 6 as host software writes it
    task automatic set_sel(input logic s);
        common_refclk_sel = s;
    endtask
    // called at a falling edge; one strobe cycle, then a quiet cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] b, output logic [31:0] q);
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cfg_be} = {w, !w, a, d, b};
        @(negedge mclk);
        q = cfg_rvalid ? cfg_rdata : 32'hx;
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {2'b00, ~a, ~d};
        @(negedge mclk);
    endtask
endmodule

// ### pdl_np_tracker.sv
`timescale 1ns/100ps
module pdl_np_tracker
    import pdl_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic np_issue,
    input  wire logic np_complete,
    output logic      pending
);
    logic [PDL_NP_CNT_W-1:0] count;
    logic [PDL_NP_CNT_W-1:0] next_count;
    logic                    inc;
    logic                    dec;

    always_comb begin
        // a completion with nothing outstanding is stray and dropped,
        // even when a fresh request goes out in the same cycle
        inc        = np_issue;
        dec        = np_complete && (count != '0);
        next_count = count;
        if (inc && !dec) begin
            next_count = count + 1'b1;
        end else if (!inc && dec) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count   <= '0;
            pending <= 1'b0;
        end else begin
            count   <= next_count;
            pending <= (next_count != '0);
        end
    end
endmodule

// ### pdl_pkg.sv
// Contract
// - status bits 15 down to 6 always read as zero.
// - nonposted_pending is set while any issued nonposted transaction awaits completion; the 6-bit count wraps, clearing it at 64 outstanding.
// - aux_power_present reads 1 when auxiliary power is detected, else 0.
// - unsupported_req_seen is set whenever an unsupported request is received.
// - fatal_err_seen is set whenever a fatal error is detected.
// - nonfatal_err_seen is set whenever a nonfatal error is detected.
// - correctable_err_seen is set whenever a correctable error is detected.
// - link capability bits 31 down to 24 always read 00h, port zero.
// - link capability bits 23 down to 18 always read zero.
// - l1_exit_time mirrors diagnostic bits 20:18 with a shared clock, 17:15 otherwise.
// - l0s_exit_time reads 011b with a shared clock and 100b otherwise.
// - aspm_support_level reads 11b, both L0s and L1 supported.
// - max_lane_width reads 00 0001b, single lane only.
// - max_link_rate reads 1h, 2.5 Gb/s.
package pdl_pkg;
    localparam logic [7:0]  PDL_OFS_DEV_STATUS  = 8'h9a;
    localparam logic [7:0]  PDL_OFS_LINK_CAPS   = 8'h9c;
    localparam logic [15:0] PDL_DEV_STATUS_RST  = 16'h0000;
    localparam int          PDL_BIT_PENDING     = 5;
    localparam int          PDL_BIT_AUX         = 4;
    localparam int          PDL_NUM_ERR         = 4;
    localparam int          PDL_ERR_LSB         = 0;
    localparam int          PDL_RSVD_STS_W      = 10;
    localparam logic [7:0]  PDL_PORT_INDEX      = 8'h00;
    localparam logic [5:0]  PDL_CAP_RSVD        = 6'h00;
    localparam logic [2:0]  PDL_L0S_SHARED      = 3'h3;
    localparam logic [2:0]  PDL_L0S_SEPARATE    = 3'h4;
    localparam logic [1:0]  PDL_ASPM_LEVEL      = 2'h3;
    localparam logic [5:0]  PDL_LANE_WIDTH      = 6'h01;
    localparam logic [3:0]  PDL_LINK_RATE       = 4'h1;
    localparam int          PDL_DIAG_SHARED_LSB = 18;
    localparam int          PDL_DIAG_SEP_LSB    = 15;
    localparam int          PDL_NP_CNT_W        = 6;
    localparam int          PDL_STS_WORD_LSB    = 16;
    localparam int          PDL_STS_BYTE_EN     = 2;
endpackage

// ### pdl_status_caps.sv
`timescale 1ns/100ps
module pdl_status_caps
    import pdl_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic [3:0]  cfg_be,
    output logic [31:0]      cfg_rdata,
    output logic             cfg_rvalid,
    input  wire logic        np_issue,
    input  wire logic        np_complete,
    input  wire logic        aux_power_in,
    input  wire logic        unsupported_req_evt,
    input  wire logic        fatal_err_evt,
    input  wire logic        nonfatal_err_evt,
    input  wire logic        correctable_err_evt,
    input  wire logic        common_refclk_sel,
    input  wire logic [2:0]  diag_l1_exit_shared_clk,
    input  wire logic [2:0]  diag_l1_exit_sep_clk,
    output logic [15:0]      device_status,
    output logic [31:0]      link_capabilities
);
    ////////////////////////////////////////////////////////////////////////////
    logic [PDL_NUM_ERR-1:0] err_evt;
    logic [PDL_NUM_ERR-1:0] err_clr;
    logic [PDL_NUM_ERR-1:0] err_flag;
    logic                   pending;
    logic                   sts_wr;

    // dword at 98h holds the status in its upper half
    assign sts_wr  = cfg_wr && (cfg_addr[7:2] == PDL_OFS_DEV_STATUS[7:2])
                     && cfg_be[PDL_STS_BYTE_EN];
    assign err_evt = {unsupported_req_evt, fatal_err_evt,
                      nonfatal_err_evt, correctable_err_evt};
    // write-one-to-clear; pending bit has no write path
    assign err_clr = sts_wr ? cfg_wdata[PDL_STS_WORD_LSB+PDL_ERR_LSB +: PDL_NUM_ERR]
                            : '0;

    genvar gi;
    generate
        for (gi = 0; gi < PDL_NUM_ERR; gi++) begin : g_err
            pdl_sticky_bit u_flag (
                .mclk    (mclk),
                .rst     (rst),
                .set_evt (err_evt[gi]),
                .clr_w1c (err_clr[gi]),
                .flag    (err_flag[gi])
            );
        end
    endgenerate

    pdl_np_tracker u_np (
        .mclk        (mclk),
        .rst         (rst),
        .np_issue    (np_issue),
        .np_complete (np_complete),
        .pending     (pending)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] next_status;
    logic [31:0] next_caps;
    logic [31:0] next_rdata;

    always_comb begin
        next_status = {{PDL_RSVD_STS_W{1'b0}}, pending, aux_power_in, err_flag};
        next_caps = {PDL_PORT_INDEX, PDL_CAP_RSVD,
                     common_refclk_sel ? diag_l1_exit_shared_clk
                                       : diag_l1_exit_sep_clk,
                     common_refclk_sel ? PDL_L0S_SHARED : PDL_L0S_SEPARATE,
                     PDL_ASPM_LEVEL, PDL_LANE_WIDTH, PDL_LINK_RATE};
        next_rdata = 32'h0000_0000;
        if (cfg_addr[7:2] == PDL_OFS_DEV_STATUS[7:2]) begin
            next_rdata = {next_status, 16'h0000};
        end else if (cfg_addr[7:2] == PDL_OFS_LINK_CAPS[7:2]) begin
            next_rdata = next_caps;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            device_status     <= PDL_DEV_STATUS_RST;
            link_capabilities <= 32'h0000_0000;
            cfg_rdata         <= 32'h0000_0000;
            cfg_rvalid        <= 1'b0;
        end else begin
            device_status     <= next_status;
            link_capabilities <= next_caps;
            cfg_rdata         <= cfg_rd ? next_rdata : 32'h0000_0000;
            cfg_rvalid        <= cfg_rd;
        end
    end
endmodule

// ### pdl_status_caps_properties.sv
`timescale 1ns/100ps
module pdl_status_caps_properties (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        cfg_wr,
    input wire logic [7:0]  cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [3:0]  cfg_be,
    input wire logic        np_issue,
    input wire logic        np_complete,
    input wire logic        fatal_err_evt,
    input wire logic        common_refclk_sel,
    input wire logic [2:0]  diag_l1_exit_shared_clk,
    input wire logic [2:0]  diag_l1_exit_sep_clk,
    input wire logic [15:0] device_status,
    input wire logic [31:0] link_capabilities
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_rsvd; device_status[15:6] == 10'h000; endproperty
    a_rsvd: assert property (p_rsvd) else $error("status upper bits set");
    property p_fix; !$past(rst) |-> link_capabilities[31:18] == 14'h0000
        && link_capabilities[11:0] == 12'hc11; endproperty
    a_fix: assert property (p_fix) else $error("fixed caps wrong");
    property p_l0s; !$past(rst) && $stable(common_refclk_sel) |->
        link_capabilities[14:12] == (common_refclk_sel ? 3'h3 : 3'h4); endproperty
    a_l0s: assert property (p_l0s) else $error("l0s exit time wrong");
    property p_l1; !$past(rst) && $stable({common_refclk_sel, diag_l1_exit_shared_clk,
        diag_l1_exit_sep_clk}) |-> link_capabilities[17:15] == (common_refclk_sel ?
        diag_l1_exit_shared_clk : diag_l1_exit_sep_clk); endproperty
    a_l1: assert property (p_l1) else $error("l1 exit time wrong");
    property p_fat; fatal_err_evt |-> ##2 device_status[2]; endproperty
    a_fat: assert property (p_fat) else $error("fatal flag not set");
    property p_stk; $fell(device_status[2]) |-> $past(cfg_wr, 2) && $past(cfg_be[2], 2)
        && $past(cfg_wdata[18], 2) && $past(cfg_addr, 2) >= 8'h98
        && $past(cfg_addr, 2) <= 8'h9b; endproperty
    a_stk: assert property (p_stk) else $error("flag dropped without write");
    property p_nonposted_pending; np_issue && !np_complete |-> ##2 device_status[5]; endproperty
    a_nonposted_pending: assert property (p_nonposted_pending) else $error("pending not set");
    property p_npclr; $fell(device_status[5]) |-> $past(np_complete, 2); endproperty
    a_npclr: assert property (p_npclr) else $error("pending dropped early");
endmodule
bind pdl_status_caps pdl_status_caps_properties u_pdl_status_caps_properties (.*);

// ### pdl_status_caps_tb.sv
`timescale 1ns/100ps
module pdl_status_caps_tb;
    logic        mclk = 1'b0, rst = 1'b1, np_issue = 1'b0, np_complete = 1'b0;
    logic        aux_power_in = 1'b0, unsupported_req_evt = 1'b0, fatal_err_evt = 1'b0;
    logic        nonfatal_err_evt = 1'b0, correctable_err_evt = 1'b0;
    logic [2:0]  diag_l1_exit_shared_clk = 3'h0, diag_l1_exit_sep_clk = 3'h0;
    logic        cfg_rd, cfg_wr, cfg_rvalid, common_refclk_sel, sel;
    logic [7:0]  cfg_addr, wa;
    logic [3:0]  cfg_be, flags = 4'h0;
    logic [31:0] cfg_wdata, cfg_rdata, link_capabilities, d, q, xc;
    logic [15:0] device_status, xs;
    int          fail_count = 0, tests_run = 0, nonposted_pending = 0;
    pdl_status_caps u_pdl_status_caps (.*);
    pdl_host u_pdl_host (.*);
    always #2 mclk = ~mclk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000 fail_count++;
        final_report;
    end
    initial begin
        void'($urandom(32'h89748ebd));
        for (int i = 0; i < 60; i++) begin
            // start-up reset, then a second one in mid-run
            if (i == 0 || i == 30) begin
                rst = 1'b1;
                repeat (i == 0 ? 16 : 2) @(negedge mclk);
                chk("reset status", 32'h0, {16'h0000, device_status});
                chk("reset caps", 32'h0, link_capabilities);
                chk("reset rvalid", 32'h0, {31'h0, cfg_rvalid});
                rst = 1'b0;
                flags = 4'h0;
                nonposted_pending = 0;
            end
            d = $urandom;
            q = $urandom;
            {np_issue, np_complete, aux_power_in, diag_l1_exit_shared_clk} = q[5:0];
            {diag_l1_exit_sep_clk, sel} = q[9:6];
            {unsupported_req_evt, fatal_err_evt, nonfatal_err_evt, correctable_err_evt} = q[13:10];
            u_pdl_host.set_sel(sel);
            nonposted_pending = nonposted_pending + int'(np_issue) - int'(np_complete && nonposted_pending > 0);
            // caps dword writes must not clear anything
            wa = q[17] ? 8'h98 : (q[20] ? 8'h9a : 8'h9c);
            flags = (flags & ~(d[19:16] & {4{q[18] && wa != 8'h9c}})) | q[13:10];
            fork
                u_pdl_host.xfer(1'b1, wa, d, q[19:16], xc);
                begin
                    @(negedge mclk);
                    {np_issue, np_complete, unsupported_req_evt} = 3'h0;
                    {fatal_err_evt, nonfatal_err_evt, correctable_err_evt} = 3'h0;
                end
            join
            repeat (3) @(negedge mclk);
            xs = {10'h000, nonposted_pending != 0, aux_power_in, flags};
            xc = {14'h0000, sel ? diag_l1_exit_shared_clk : diag_l1_exit_sep_clk,
                  sel ? 3'h3 : 3'h4, 12'hc11};
            u_pdl_host.xfer(1'b0, 8'h9a, d, 4'h0, q);
            chk("status read", {xs, 16'h0000}, q);
            chk("status port", {16'h0000, xs}, {16'h0000, device_status});
            u_pdl_host.xfer(1'b0, 8'h9c, d, 4'h0, q);
            chk("caps read", xc, q);
            chk("caps port", xc, link_capabilities);
            u_pdl_host.xfer(1'b0, {1'b0, d[6:0]}, d, 4'h0, q);
            chk("unmapped read", 32'h0, q);
        end
        final_report;
    end
endmodule

// ### pdl_sticky_bit.sv
`timescale 1ns/100ps
module pdl_sticky_bit
    import pdl_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic set_evt,
    input  wire logic clr_w1c,
    output logic      flag
);
    logic next_flag;

    always_comb begin
        // set beats a clear in the same cycle
        next_flag = set_evt | (flag & ~clr_w1c);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule
